// File: t1_event_flags.sv
// Event flags, counter overflow latches and their Wishbone register slave
//
// Contract
// - HDLC events set flag bits 7, 6, 5
// - Reading event flags returns then clears them
// - Loop code held 48 ms sets bit 4
// - One-second status rising edge sets bit 3
// - Five-second status rising edge sets bit 2
// - New valid bit message sets bit 1
// - Message accepted only with 8 of 10
// - Signaling change sets bit 0, debounce selectable
// - Eight counter overflows set latch bits 7..0
// - Latch bits hold until read clears them
// - Overflow means counter wraps FFH to 00H
//
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
`include "t1_event_map.svh"

module t1_event_flags #(
   parameter int LOOP_HOLD_CYCLES = `LOOP_HOLD_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   // Event sources
   input wire logic [2:0] hdlc_event_i,
   input wire logic loop_up_seen_i,
   input wire logic loop_down_seen_i,
   input wire logic one_second_status_i,
   input wire logic five_second_status_i,
   input wire logic bom_valid_i,
   input wire logic [14:0] bom_word_i,
   input wire logic sig_change_raw_i,
   input wire logic sig_change_deb_i,
   input wire logic [63:0] err_count_i
);

   // Byte-lane merge for a writable byte
   function automatic logic [7:0] lane_write(input logic [7:0] old,
         input logic [7:0] data, input logic en);
      lane_write = en ? data : old;
   endfunction : lane_write

   t1_event_pkg::flag_byte_t event_flag_word; // Clear-on-read event flags
   t1_event_pkg::flag_byte_t counter_overflow_latches; // Clear-on-read
   t1_event_pkg::flag_byte_t event_mask; // One means unmasked
   t1_event_pkg::flag_byte_t control; // Bit 0 is debounce_enable
   t1_event_pkg::irq_word_t irq_status; // Sticky, write one to clear
   t1_event_pkg::irq_word_t irq_mask; // One lets a status bit through
   t1_event_pkg::flag_byte_t event_set; // Raw events this cycle, masked
   t1_event_pkg::flag_byte_t ovf_set; // Counter wraps this cycle
   t1_event_pkg::reg_sel_e reg_sel; // Decoded register
   logic [63:0] prev_count; // Counter values one cycle ago
   logic one_sec_prev; // Edge detect history
   logic five_sec_prev;
   logic [19:0] loop_cnt; // Time the loop code has been present
   logic loop_hit; // Loop code has just reached the hold time
   logic loop_done; // Stops repeat hits during one long run
   t1_event_pkg::bom_hist_t bom_hist; // Ten entries of match bit plus code
   t1_event_pkg::bom_hist_t next_bom_hist;
   t1_event_pkg::bom_code_t bom_code; // Message currently accepted
   logic bom_known; // A message has been accepted since reset
   logic bom_match; // Incoming word fits the message pattern
   logic [3:0] bom_votes; // Matches of the incoming code in the window
   logic bom_accept; // New differing message accepted this cycle
   logic debounce_enable;
   logic req; // Bus request awaiting its answer
   logic rd_event; // Read of the event flags is being answered
   logic rd_ovf; // Read of the overflow latches is being answered
   logic wr; // Write being answered

   assign debounce_enable = control[`DEBOUNCE_ENABLE_BIT];
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;
   assign rd_event = req && !wb_we_i && reg_sel == t1_event_pkg::SEL_EVENT;
   assign rd_ovf = req && !wb_we_i && reg_sel == t1_event_pkg::SEL_OVF;

   // Address decode; anything unmapped reads zero and ignores writes
   always_comb begin
      unique case (wb_adr_i)
         `EVENT_FLAG_ADR: reg_sel = t1_event_pkg::SEL_EVENT;
         `OVF_LATCH_ADR: reg_sel = t1_event_pkg::SEL_OVF;
         `EVENT_MASK_ADR: reg_sel = t1_event_pkg::SEL_MASK;
         `CONTROL_ADR: reg_sel = t1_event_pkg::SEL_CTRL;
         `STATUS_ADR: reg_sel = t1_event_pkg::SEL_STAT;
         `IRQ_STATUS_ADR: reg_sel = t1_event_pkg::SEL_IRQS;
         `IRQ_MASK_ADR: reg_sel = t1_event_pkg::SEL_IRQM;
         default: reg_sel = t1_event_pkg::SEL_NONE;
      endcase
   end

   // Loop code timer; restarts whenever neither code is present
   always_ff @(posedge clk_i) begin
      if (rst_i || !(loop_up_seen_i || loop_down_seen_i)) begin
         loop_cnt <= 20'h00000;
         loop_done <= 1'b0;
      end else if (!loop_done) begin
         if (loop_hit) begin
            loop_done <= 1'b1; // One flag per continuous run
         end else begin
            loop_cnt <= loop_cnt + 20'h00001;
         end
      end
   end
   assign loop_hit = !loop_done && (loop_up_seen_i || loop_down_seen_i) &&
      loop_cnt == 20'(LOOP_HOLD_CYCLES - 1);

   // Edge detection history for the timer status bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         one_sec_prev <= 1'b0;
         five_sec_prev <= 1'b0;
      end else begin
         one_sec_prev <= one_second_status_i;
         five_sec_prev <= five_second_status_i;
      end
   end

   // Bit message window: newest entry in the low seven bits
   assign bom_match = bom_word_i[14:7] == `BOM_HEAD && !bom_word_i[0];
   assign next_bom_hist = {bom_hist[62:0], bom_match, bom_word_i[6:1]};
   always_comb begin
      bom_votes = 4'h0;
      for (int i = 0; i < `BOM_DEPTH; i++) begin
         if (next_bom_hist[7*i+6] &&
               next_bom_hist[7*i +: 6] == bom_word_i[6:1]) begin
            bom_votes = bom_votes + 4'h1;
         end
      end
   end
   // Accept only a persistent message that differs from the last one
   assign bom_accept = bom_valid_i && bom_match &&
      bom_votes >= 4'(`BOM_VOTES) &&
      (!bom_known || bom_code != bom_word_i[6:1]);

   // Message history and accepted message
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bom_hist <= '0;
         bom_code <= 6'h00;
         bom_known <= 1'b0;
      end else if (bom_valid_i) begin
         bom_hist <= next_bom_hist;
         if (bom_accept) begin
            bom_code <= bom_word_i[6:1];
            bom_known <= 1'b1;
         end
      end
   end

   // Raw events gated by the event mask
   always_comb begin
      event_set = 8'h00;
      event_set[`HDLC_ZERO_BIT] = hdlc_event_i[0];
      event_set[`HDLC_ONE_BIT] = hdlc_event_i[1];
      event_set[`HDLC_TWO_BIT] = hdlc_event_i[2];
      event_set[`LOOP_CODE_BIT] = loop_hit;
      event_set[`ONE_SECOND_BIT] = one_second_status_i &&
         !one_sec_prev;
      event_set[`FIVE_SECOND_BIT] = five_second_status_i &&
         !five_sec_prev;
      event_set[`BIT_MESSAGE_BIT] = bom_accept;
      event_set[`SIGNALING_BIT] = debounce_enable ? sig_change_deb_i :
         sig_change_raw_i;
      event_set = event_set & event_mask;
   end

   // Counter wrap detection: previous value FFH and now 00H
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_count <= 64'h0000000000000000;
      end else begin
         prev_count <= err_count_i;
      end
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         ovf_set[i] = prev_count[8*i +: 8] == `COUNTER_TOP &&
            err_count_i[8*i +: 8] == `COUNTER_ZERO;
      end
   end

   // Event flags: cleared by the answered read, a new event wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_flag_word <= `FLAG_RST;
      end else if (rd_event) begin
         event_flag_word <= event_set;
      end else begin
         event_flag_word <= event_flag_word | event_set;
      end
   end

   // Overflow latches: held until read, a coinciding wrap is kept
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         counter_overflow_latches <= `FLAG_RST;
      end else if (rd_ovf) begin
         counter_overflow_latches <= ovf_set;
      end else begin
         counter_overflow_latches <= counter_overflow_latches |
            ovf_set;
      end
   end

   // Software writable mask and control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_mask <= `EVENT_MASK_RST;
         control <= `CONTROL_RST;
         irq_mask <= `IRQ_MASK_RST;
      end else if (wr) begin
         if (reg_sel == t1_event_pkg::SEL_MASK) begin
            event_mask <= lane_write(event_mask, wb_dat_i[7:0], wb_sel_i[0]);
         end
         if (reg_sel == t1_event_pkg::SEL_CTRL) begin
            control <= lane_write(control, {7'h00, wb_dat_i[0]}, wb_sel_i[0]);
         end
         if (reg_sel == t1_event_pkg::SEL_IRQM) begin
            irq_mask[7:0] <= lane_write(irq_mask[7:0], wb_dat_i[7:0],
               wb_sel_i[0]);
            irq_mask[15:8] <= lane_write(irq_mask[15:8], wb_dat_i[15:8],
               wb_sel_i[1]);
         end
      end
   end

   // Interrupt status: low byte event flags, high byte overflows.
   // Write one clears, but a set in the same cycle survives.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= 16'h0000;
      end else if (wr && reg_sel == t1_event_pkg::SEL_IRQS) begin
         irq_status <= (irq_status & ~(wb_dat_i[15:0] &
            {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}})) | {ovf_set, event_set};
      end else begin
         irq_status <= irq_status | {ovf_set, event_set};
      end
   end

   // Interrupt line, registered so it comes straight from a flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // Bus answer one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Read data captured with the answer; the read clear acts at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (req && !wb_we_i) begin
         unique case (reg_sel)
            t1_event_pkg::SEL_EVENT: wb_dat_o <= {24'h000000, event_flag_word};
            t1_event_pkg::SEL_OVF:
               wb_dat_o <= {24'h000000, counter_overflow_latches};
            t1_event_pkg::SEL_MASK: wb_dat_o <= {24'h000000, event_mask};
            t1_event_pkg::SEL_CTRL: wb_dat_o <= {24'h000000, control};
            t1_event_pkg::SEL_STAT: wb_dat_o <= {29'h0000000, loop_done,
               five_second_status_i, one_second_status_i};
            t1_event_pkg::SEL_IRQS: wb_dat_o <= {16'h0000, irq_status};
            t1_event_pkg::SEL_IRQM: wb_dat_o <= {16'h0000, irq_mask};
            t1_event_pkg::SEL_NONE: wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   // Checks kept beside the logic they guard
   sequence bus_req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ack_pulse_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req_s |=> ack_pulse_s)
      else $error("bus answer not a single cycle after request");

   hdlc_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      hdlc_event_i[2] && event_mask[`HDLC_TWO_BIT] |=>
      event_flag_word[`HDLC_TWO_BIT])
      else $error("third controller event did not set its flag");

   read_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_event && event_set == 8'h00 |=>
      event_flag_word == 8'h00 && wb_dat_o[7:0] == $past(event_flag_word))
      else $error("event flag read did not return and clear");

   loop_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
      loop_hit |-> loop_cnt == 20'(LOOP_HOLD_CYCLES - 1) &&
      (loop_up_seen_i || loop_down_seen_i) ##1
      (!event_mask[`LOOP_CODE_BIT] || event_flag_word[`LOOP_CODE_BIT] ||
      $past(rd_event)))
      else $error("loop code flag timing wrong");

   one_sec_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(one_second_status_i) && event_mask[`ONE_SECOND_BIT] |=>
      event_flag_word[`ONE_SECOND_BIT])
      else $error("one second edge lost");

   five_sec_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(five_second_status_i) && event_mask[`FIVE_SECOND_BIT] |=>
      event_flag_word[`FIVE_SECOND_BIT])
      else $error("five second edge lost");

   bom_new_a: assert property (@(posedge clk_i) disable iff (rst_i)
      bom_accept && event_mask[`BIT_MESSAGE_BIT] |=>
      event_flag_word[`BIT_MESSAGE_BIT] && bom_code == $past(bom_word_i[6:1]))
      else $error("accepted message did not raise its flag");

   bom_vote_a: assert property (@(posedge clk_i) disable iff (rst_i)
      bom_accept |-> bom_votes >= 4'h8 && bom_match)
      else $error("message accepted without enough votes");

   sig_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      debounce_enable && sig_change_deb_i && event_mask[`SIGNALING_BIT] |=>
      event_flag_word[`SIGNALING_BIT])
      else $error("debounced signaling change lost");

   ovf_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      prev_count[63:56] == 8'hFF && err_count_i[63:56] == 8'h00 |=>
      counter_overflow_latches[7])
      else $error("framing counter wrap not latched");

   ovf_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !rd_ovf |=> (counter_overflow_latches & $past(counter_overflow_latches))
      == $past(counter_overflow_latches))
      else $error("overflow latch dropped without a read");

   set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_ovf |=> counter_overflow_latches == $past(ovf_set))
      else $error("overflow coinciding with read was lost");

endmodule : t1_event_flags

// File: t1_event_map.svh
// Offsets, field positions, reset values and timing counts for the flag block
`ifndef T1_EVENT_MAP_SVH
`define T1_EVENT_MAP_SVH

// Register indexes as printed; byte address is four times the index
`define EVENT_FLAG_IDX 8'h1E
`define OVF_LATCH_IDX 8'h1F
`define EVENT_FLAG_ADR 8'h78
`define OVF_LATCH_ADR 8'h7C

// Additional registers for masks, control, status and interrupts
`define EVENT_MASK_ADR 8'h00
`define CONTROL_ADR 8'h04
`define STATUS_ADR 8'h08
`define IRQ_STATUS_ADR 8'h0C
`define IRQ_MASK_ADR 8'h10

// Event flag field positions
`define HDLC_ZERO_BIT 7
`define HDLC_ONE_BIT 6
`define HDLC_TWO_BIT 5
`define LOOP_CODE_BIT 4
`define ONE_SECOND_BIT 3
`define FIVE_SECOND_BIT 2
`define BIT_MESSAGE_BIT 1
`define SIGNALING_BIT 0

// Control and status field positions
`define DEBOUNCE_ENABLE_BIT 0
`define STAT_ONE_SEC_BIT 0
`define STAT_FIVE_SEC_BIT 1
`define STAT_LOOP_BIT 2

// Reset values
`define EVENT_MASK_RST 8'hFF
`define CONTROL_RST 8'h00
`define IRQ_MASK_RST 16'h0000
`define FLAG_RST 8'h00

// Loop code hold time and clock rate
`define LOOP_HOLD_MS 48
`define CLOCK_HZ 20000000
`define LOOP_HOLD_CYCLES ((`LOOP_HOLD_MS * `CLOCK_HZ + 999) / 1000)

// Bit oriented message pattern and voting figures, counter wrap values
`define BOM_HEAD 8'hFE
`define BOM_DEPTH 10
`define BOM_VOTES 8
`define COUNTER_TOP 8'hFF
`define COUNTER_ZERO 8'h00

`endif

// File: t1_event_pkg.sv
// Types shared by the event flag and overflow latch block
package t1_event_pkg;
   typedef logic [7:0] flag_byte_t;
   typedef logic [15:0] irq_word_t;
   typedef logic [5:0] bom_code_t;
   typedef logic [69:0] bom_hist_t;
   // Register select decoded from the bus address
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_EVENT = 3'b001,
      SEL_OVF = 3'b010,
      SEL_MASK = 3'b011,
      SEL_CTRL = 3'b100,
      SEL_STAT = 3'b101,
      SEL_IRQS = 3'b110,
      SEL_IRQM = 3'b111
   } reg_sel_e;
endpackage : t1_event_pkg

// File: test_t1_event_flags.sv
// Self-checking testbench for the event flag and overflow latch block
`timescale 1ns/10ps
`include "t1_event_map.svh"

module test_t1_event_flags;
   // Compare, count and report one value
   `define CHECK(what, exp, got) begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("BAD %s expected %h seen %h", what, exp, got); \
      end \
   end
   localparam int HOLD = 16; // Shortened loop code hold time
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [2:0] hdlc_event_i;
   logic loop_up_seen_i, loop_down_seen_i, bom_valid_i;
   logic one_second_status_i, five_second_status_i;
   logic sig_change_raw_i, sig_change_deb_i;
   logic [14:0] bom_word_i;
   logic [63:0] err_count_i;
   int fails = 0;
   int samples_checked = 0;

   t1_event_flags #(.LOOP_HOLD_CYCLES(HOLD)) i_t1_event_flags (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .irq_o(irq_o), .hdlc_event_i(hdlc_event_i),
      .loop_up_seen_i(loop_up_seen_i), .loop_down_seen_i(loop_down_seen_i),
      .one_second_status_i(one_second_status_i),
      .five_second_status_i(five_second_status_i),
      .bom_valid_i(bom_valid_i), .bom_word_i(bom_word_i),
      .sig_change_raw_i(sig_change_raw_i), .sig_change_deb_i(sig_change_deb_i),
      .err_count_i(err_count_i));

   // 20 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // One classic Wishbone cycle; ev pulses the HDLC events with the request
   task automatic xfer(input logic we, input logic [7:0] adr,
         input logic [31:0] wd, input logic [2:0] ev);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      wb_sel_i <= 4'h3;
      hdlc_event_i <= ev;
      // Hold the request until ack is sampled high, bounded wait
      do begin
         @(posedge clk_i);
         hdlc_event_i <= 3'h0;
         n++;
      end while (wb_ack_o !== 1'b1 && n < 64);
      if (n >= 64) begin
         fails++;
         $display("BAD bus answer expected ack seen none");
         print_verdict();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : xfer

   task automatic rdreg(input logic [7:0] adr);
      xfer(1'b0, adr, 32'h0, 3'h0);
   endtask : rdreg

   task automatic wrreg(input logic [7:0] adr, input logic [31:0] wd);
      xfer(1'b1, adr, wd, 3'h0);
   endtask : wrreg

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   // Reset values, unmapped place and write to a read-only register
   task automatic t_reset_values;
      rdreg(`EVENT_MASK_ADR); `CHECK("mask", 32'hFF, rd)
      rdreg(`CONTROL_ADR); `CHECK("control", 32'h0, rd)
      rdreg(`IRQ_MASK_ADR); `CHECK("irq mask", 32'h0, rd)
      rdreg(`EVENT_FLAG_ADR); `CHECK("flags", 32'h0, rd)
      rdreg(`OVF_LATCH_ADR); `CHECK("latches", 32'h0, rd)
      wrreg(8'h40, 32'hFF);
      rdreg(8'h40); `CHECK("unmapped", 32'h0, rd)
      wrreg(`EVENT_FLAG_ADR, 32'hFF);
      rdreg(`EVENT_FLAG_ADR); `CHECK("ro flags", 32'h0, rd)
      $display("test reset values done");
   endtask : t_reset_values

   // HDLC flags, clear on read, masking and an event during the read
   task automatic t_hdlc;
      @(posedge clk_i) hdlc_event_i <= 3'h7;
      @(posedge clk_i) hdlc_event_i <= 3'h0;
      rdreg(`EVENT_FLAG_ADR); `CHECK("hdlc", 32'hE0, rd)
      rdreg(`EVENT_FLAG_ADR); `CHECK("cleared", 32'h0, rd)
      wrreg(`EVENT_MASK_ADR, 32'h7F);
      @(posedge clk_i) hdlc_event_i <= 3'h7;
      @(posedge clk_i) hdlc_event_i <= 3'h0;
      rdreg(`EVENT_FLAG_ADR); `CHECK("masked", 32'h60, rd)
      wrreg(`EVENT_MASK_ADR, 32'hFF);
      // An event in the clearing cycle must survive
      xfer(1'b0, `EVENT_FLAG_ADR, 32'h0, 3'h2);
      `CHECK("old", 32'h0, rd)
      rdreg(`EVENT_FLAG_ADR); `CHECK("kept", 32'h40, rd)
      $display("test hdlc done");
   endtask : t_hdlc

   // Seconds status edges; a held level must not set again
   task automatic t_seconds;
      @(posedge clk_i) one_second_status_i <= 1'b1;
      tick(2);
      rdreg(`EVENT_FLAG_ADR); `CHECK("1s", 32'h08, rd)
      rdreg(`EVENT_FLAG_ADR); `CHECK("1s held", 32'h0, rd)
      @(posedge clk_i) one_second_status_i <= 1'b0;
      five_second_status_i <= 1'b1;
      tick(2);
      rdreg(`EVENT_FLAG_ADR); `CHECK("5s", 32'h04, rd)
      five_second_status_i <= 1'b0;
      $display("test seconds done");
   endtask : t_seconds

   // Loop codes: one cycle short, then full runs of each code
   task automatic t_loop;
      @(posedge clk_i) loop_up_seen_i <= 1'b1;
      tick(HOLD - 1);
      loop_up_seen_i <= 1'b0;
      tick(4);
      rdreg(`EVENT_FLAG_ADR); `CHECK("short", 32'h0, rd)
      @(posedge clk_i) loop_up_seen_i <= 1'b1;
      tick(HOLD + 4);
      // Run still present: the status word reports it complete
      rdreg(`STATUS_ADR); `CHECK("run done", 32'h4, rd)
      loop_up_seen_i <= 1'b0;
      rdreg(`EVENT_FLAG_ADR); `CHECK("up", 32'h10, rd)
      @(posedge clk_i) loop_down_seen_i <= 1'b1;
      tick(HOLD + 4);
      loop_down_seen_i <= 1'b0;
      rdreg(`EVENT_FLAG_ADR); `CHECK("down", 32'h10, rd)
      $display("test loop code done");
   endtask : t_loop

   task automatic bom(input logic [14:0] w, input int n);
      repeat (n) begin
         @(posedge clk_i);
         bom_valid_i <= 1'b1;
         bom_word_i <= w;
      end
      @(posedge clk_i) bom_valid_i <= 1'b0;
      tick(2);
   endtask : bom

   // Bit messages: 7 of 10 refused, 8 accepted, repeat ignored, new taken
   task automatic t_bom;
      logic [14:0] ma, mb;
      ma = {`BOM_HEAD, 6'h15, 1'b0};
      mb = {`BOM_HEAD, 6'h2A, 1'b0};
      bom(15'h0, 10);
      bom(ma, 7);
      bom(15'h0, 3);
      rdreg(`EVENT_FLAG_ADR); `CHECK("7 of 10", 32'h0, rd)
      bom(15'h0, 10);
      bom(ma, 8);
      rdreg(`EVENT_FLAG_ADR); `CHECK("8 of 10", 32'h02, rd)
      bom(ma, 10);
      rdreg(`EVENT_FLAG_ADR); `CHECK("same", 32'h0, rd)
      bom(mb, 10);
      rdreg(`EVENT_FLAG_ADR); `CHECK("new", 32'h02, rd)
      $display("test bit message done");
   endtask : t_bom

   // Signaling change, raw and then debounced source
   task automatic t_sig;
      @(posedge clk_i) sig_change_deb_i <= 1'b1;
      @(posedge clk_i) sig_change_deb_i <= 1'b0;
      rdreg(`EVENT_FLAG_ADR); `CHECK("deb off", 32'h0, rd)
      @(posedge clk_i) sig_change_raw_i <= 1'b1;
      @(posedge clk_i) sig_change_raw_i <= 1'b0;
      rdreg(`EVENT_FLAG_ADR); `CHECK("raw", 32'h01, rd)
      wrreg(`CONTROL_ADR, 32'h1);
      @(posedge clk_i) sig_change_raw_i <= 1'b1;
      @(posedge clk_i) sig_change_raw_i <= 1'b0;
      rdreg(`EVENT_FLAG_ADR); `CHECK("raw off", 32'h0, rd)
      @(posedge clk_i) sig_change_deb_i <= 1'b1;
      @(posedge clk_i) sig_change_deb_i <= 1'b0;
      rdreg(`EVENT_FLAG_ADR); `CHECK("deb", 32'h01, rd)
      $display("test signaling done");
   endtask : t_sig

   // Each counter wraps in turn; a near wrap must not latch
   task automatic t_ovf;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i) err_count_i[8*i +: 8] <= `COUNTER_TOP;
         @(posedge clk_i) err_count_i[8*i +: 8] <= `COUNTER_ZERO;
         tick(2);
         rdreg(`OVF_LATCH_ADR); `CHECK("latch", 32'h1 << i, rd)
      end
      @(posedge clk_i) err_count_i[7:0] <= 8'hFE;
      @(posedge clk_i) err_count_i[7:0] <= 8'h00;
      tick(2);
      rdreg(`OVF_LATCH_ADR); `CHECK("no wrap", 32'h0, rd)
      $display("test overflow done");
   endtask : t_ovf

   // Interrupt output: sticky status, mask and write-one-to-clear
   task automatic t_irq;
      // Every event kind and all eight wraps have happened by now
      rdreg(`IRQ_STATUS_ADR); `CHECK("irq all", 32'hFFFF, rd)
      wrreg(`IRQ_STATUS_ADR, 32'hFFFF);
      @(posedge clk_i) hdlc_event_i <= 3'h1;
      @(posedge clk_i) hdlc_event_i <= 3'h0;
      tick(3);
      `CHECK("irq masked", 1'b0, irq_o)
      rdreg(`IRQ_STATUS_ADR); `CHECK("irq status", 32'h0080, rd)
      wrreg(`IRQ_MASK_ADR, 32'h0080);
      tick(2);
      `CHECK("irq high", 1'b1, irq_o)
      wrreg(`IRQ_STATUS_ADR, 32'h0080);
      tick(2);
      `CHECK("irq low", 1'b0, irq_o)
      rdreg(`EVENT_FLAG_ADR); `CHECK("flag", 32'h80, rd)
      $display("test interrupt done");
   endtask : t_irq

   // Closing report and verdict
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   // Watchdog: the tests need well under 3000 cycles
   initial begin
      tick(20000);
      fails++;
      $display("BAD watchdog expected finish seen hang");
      print_verdict();
   end

   // Main sequence
   initial begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, bom_valid_i} = 4'h0;
      {loop_up_seen_i, loop_down_seen_i} = 2'b00;
      {one_second_status_i, five_second_status_i} = 2'b00;
      {sig_change_raw_i, sig_change_deb_i} = 2'b00;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      hdlc_event_i = 3'h0;
      bom_word_i = 15'h0;
      err_count_i = 64'h0;
      tick(16);
      rst_i <= 1'b0;
      t_reset_values();
      t_hdlc();
      t_seconds();
      t_loop();
      t_bom();
      t_sig();
      t_ovf();
      t_irq();
      print_verdict();
   end
endmodule : test_t1_event_flags
